// ==== src/afc_ctrl.sv ====
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
// host controller for an asynchronous strobe-driven FIFO group
module afc_ctrl #(
  parameter int DW = 9,
  parameter int N_DEV = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // strobes and controls toward the FIFO group
  output logic load_pulse_n,
  output logic unload_pulse_n,
  output logic clear_input,
  output logic replay_strobe,
  output logic lead_unit_select,
  output logic [DW-1:0] fifo_din,
  // flags and data from the FIFO group
  input wire logic [N_DEV-1:0] full_flag_n,
  input wire logic [N_DEV-1:0] empty_indicator_n,
  input wire logic half_level_indicator_n,
  input wire logic [DW-1:0] fifo_dout
);
  afc_pkg::afc_state_t state_q, state_d;
  logic [afc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [N_DEV-1:0] full_s, empty_s;
  logic half_s;
  logic [DW-1:0] dout_s;
  logic ack_q;
  logic [31:0] dat_q;
  logic lead_q;
  logic depth_q;
  logic refused_q;
  logic rvalid_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] din_q;
  logic wr_n_q, rd_n_q, clr_q, rt_q;

  // flags and read data all come from another timing domain
  afc_sync3 #(.W(2 * N_DEV + 1), .RST_VAL('0)) u_flag_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_i({full_flag_n, empty_indicator_n, half_level_indicator_n}),
    .sync_o({full_s, empty_s, half_s})
  );
  afc_sync3 #(.W(DW), .RST_VAL('0)) u_data_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_i(fifo_dout),
    .sync_o(dout_s)
  );

  // composite flags: low only when every device is low
  // one flag per device, whether chained in a ring or built up as a compound array
  wire logic full_n_comp = |full_s;
  wire logic empty_n_comp = |empty_s;
  // half-level taken from device 0 alone, meaningless in depth mode
  wire logic half_n = half_s | depth_q;

  // bus decode
  wire logic idle = (state_q == afc_pkg::ST_IDLE);
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire logic hit_ctrl = (wb_adr_i == afc_pkg::REG_CTRL);
  wire logic hit_wdata = (wb_adr_i == afc_pkg::REG_WDATA);
  wire logic hit_rcmd = (wb_adr_i == afc_pkg::REG_RCMD);
  wire logic hit_rdata = (wb_adr_i == afc_pkg::REG_RDATA);
  wire logic hit_status = (wb_adr_i == afc_pkg::REG_STATUS);
  wire logic ask_clr = bus_wr & hit_ctrl & wb_dat_i[afc_pkg::CTRL_CLEAR_BIT];
  wire logic ask_rt = bus_wr & hit_ctrl & wb_dat_i[afc_pkg::CTRL_REPLAY_BIT];
  wire logic ask_wr = bus_wr & hit_wdata;
  wire logic ask_rd = bus_wr & hit_rcmd;
  // a write may start only while the full flag is released
  wire logic go_wr = ask_wr & idle & full_n_comp;
  // a read may start only while the empty flag is released
  wire logic go_rd = ask_rd & idle & empty_n_comp;
  wire logic go_clr = ask_clr & idle;
  // replay is refused in depth mode where it does not exist
  wire logic go_rt = ask_rt & idle & ~ask_clr & ~depth_q;
  wire logic refuse = (ask_wr & ~go_wr) | (ask_rd & ~go_rd) | (ask_clr & ~go_clr)
                    | (ask_rt & ~ask_clr & ~go_rt);
  wire logic clr_refused = bus_wr & hit_status & wb_dat_i[afc_pkg::ST_REFUSED_BIT];
  wire logic cnt_done = (cnt_q == afc_pkg::CNT_ZERO);
  wire logic cnt_dec = ~cnt_done;
  wire logic capture = (state_q == afc_pkg::ST_RD_LOW) & cnt_done;

  // read mux for the bus
  wire logic [31:0] status_word = {26'h0, rvalid_q, refused_q, ~idle, half_n,
                                   empty_n_comp, full_n_comp};
  wire logic [31:0] ctrl_word = {28'h0, depth_q, lead_q, 2'h0};
  wire logic [31:0] rdata_word = {{(32 - DW){1'b0}}, rdata_q};
  wire logic [31:0] rd_mux = hit_status ? status_word :
                             hit_ctrl ? ctrl_word :
                             hit_rdata ? rdata_word : 32'h0;

  // sequencer: every pin cycle is a low phase then a recovery phase
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_dec ? cnt_q - afc_pkg::CNT_ONE : cnt_q;
    case (state_q)
      afc_pkg::ST_IDLE: begin
        if (go_clr) begin
          state_d = afc_pkg::ST_CLR_LOW;
          cnt_d = afc_pkg::CLEAR_CYC;
        end else if (go_rt) begin
          state_d = afc_pkg::ST_RT_LOW;
          cnt_d = afc_pkg::STROBE_CYC;
        end else if (go_wr) begin
          state_d = afc_pkg::ST_WR_LOW;
          cnt_d = afc_pkg::STROBE_CYC;
        end else if (go_rd) begin
          state_d = afc_pkg::ST_RD_LOW;
          cnt_d = afc_pkg::READ_CYC;
        end
      end
      // rising load edge at the end of this phase stores the word
      afc_pkg::ST_WR_LOW: begin
        if (cnt_done) begin
          state_d = afc_pkg::ST_WR_REC;
          cnt_d = afc_pkg::REC_CYC;
        end
      end
      afc_pkg::ST_RD_LOW: begin
        if (cnt_done) begin
          state_d = afc_pkg::ST_RD_REC;
          cnt_d = afc_pkg::REC_CYC;
        end
      end
      afc_pkg::ST_CLR_LOW: begin
        if (cnt_done) begin
          state_d = afc_pkg::ST_CLR_REC;
          cnt_d = afc_pkg::REC_CYC;
        end
      end
      afc_pkg::ST_RT_LOW: begin
        if (cnt_done) begin
          state_d = afc_pkg::ST_RT_REC;
          cnt_d = afc_pkg::REC_CYC;
        end
      end
      // recovery lets flags settle through the synchroniser first
      afc_pkg::ST_WR_REC, afc_pkg::ST_RD_REC, afc_pkg::ST_CLR_REC,
      afc_pkg::ST_RT_REC: begin
        if (cnt_done) begin
          state_d = afc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = afc_pkg::ST_IDLE;
        cnt_d = afc_pkg::CNT_ZERO;
      end
    endcase
  end

  // the group is cleared once automatically after our own reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= afc_pkg::ST_CLR_LOW;
      cnt_q <= afc_pkg::CLEAR_CYC;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // pin drive; strobes stay high during clear and replay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      clr_q <= 1'b0;
      rt_q <= 1'b1;
    end else begin
      wr_n_q <= (state_d != afc_pkg::ST_WR_LOW);
      rd_n_q <= (state_d != afc_pkg::ST_RD_LOW);
      clr_q <= (state_d != afc_pkg::ST_CLR_LOW);
      rt_q <= (state_d != afc_pkg::ST_RT_LOW);
    end
  end

  // write data latched at command time, held through the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_q <= '0;
    end else if (go_wr) begin
      din_q <= wb_dat_i[DW-1:0];
    end
  end

  // read word sampled late in the low phase after access and sync delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else if (capture) begin
      rdata_q <= dout_s;
      rvalid_q <= 1'b1;
    end else if (bus_req & ~wb_we_i & hit_rdata) begin
      rvalid_q <= 1'b0;
    end
  end

  // configuration bits: lead select low marks the first chain device, high any other
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_q <= afc_pkg::CTRL_LEAD_RST;
      depth_q <= afc_pkg::CTRL_DEPTH_RST;
    end else if (bus_wr & hit_ctrl) begin
      lead_q <= wb_dat_i[afc_pkg::CTRL_LEAD_BIT];
      depth_q <= wb_dat_i[afc_pkg::CTRL_DEPTH_BIT];
    end
  end

  // sticky refusal; a new refusal wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (refuse) begin
      refused_q <= 1'b1;
    end else if (clr_refused) begin
      refused_q <= 1'b0;
    end
  end

  // one-cycle ack with registered read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= bus_req;
      dat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign load_pulse_n = wr_n_q;
  assign unload_pulse_n = rd_n_q;
  assign clear_input = clr_q;
  assign replay_strobe = rt_q;
  assign lead_unit_select = lead_q;
  assign fifo_din = din_q;
endmodule // afc_ctrl

// ==== src/afc_pkg.sv ====
// Summary of operation
// - writer watches full, reader watches empty.
// - first chain device holds lead_unit_select low.
// - other chain devices hold lead_unit_select high.
// - each chain_out feeds next chain_in, ring.
// - composite flags assert only when all assert.
// - width expansion drives controls in common.
// - width-group flags read from any device.
// - write only when full deasserted and toggled.
// - pairing and compound arrays are allowed.
package afc_pkg;
  // controller register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RCMD = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // control register fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_REPLAY_BIT = 1;
  localparam int CTRL_LEAD_BIT = 2;
  localparam int CTRL_DEPTH_BIT = 3;
  // status register fields
  localparam int ST_FULL_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_HALF_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_RVALID_BIT = 5;
  // reset values of control fields
  localparam logic CTRL_LEAD_RST = 1'b0;
  localparam logic CTRL_DEPTH_RST = 1'b0;
  // pin timing in ns and the cycle counts derived from it
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_LOW_NS = 40;
  localparam int ACCESS_NS = 30;
  localparam int RECOVERY_NS = 20;
  localparam int CLEAR_LOW_NS = 60;
  localparam int SYNC_LAT = 3;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT + 1);
  localparam logic [CNT_W-1:0] REC_CYC =
    CNT_W'((RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT + 1);
  localparam logic [CNT_W-1:0] CLEAR_CYC =
    CNT_W'((CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_LOW, ST_WR_REC, ST_RD_LOW, ST_RD_REC,
    ST_CLR_LOW, ST_CLR_REC, ST_RT_LOW, ST_RT_REC
  } afc_state_t;
endpackage

// ==== src/afc_sync3.sv ====
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves once stages two and three agree
module afc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pin side and synchronised side
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire logic agree = (s2_q == s3_q);

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filter out a value still settling between stages
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_o <= RST_VAL;
    end else if (agree) begin
      sync_o <= s3_q;
    end
  end
endmodule // afc_sync3

// ==== testbench/afc_ctrl_monitor.sv ====
`timescale 1ns/100ps
// bus and strobe pin checks on the controller
module afc_ctrl_monitor #(
  parameter int DW = 9
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // device side
  input wire logic load_pulse_n,
  input wire logic unload_pulse_n,
  input wire logic clear_input,
  input wire logic replay_strobe,
  input wire logic [DW-1:0] fifo_din
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // taken write requests, decoded once
  wire logic wr_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire logic wr_data = wr_req && wb_adr_i == afc_pkg::REG_WDATA;
  wire logic wr_rcmd = wr_req && wb_adr_i == afc_pkg::REG_RCMD;
  // strobe shapes: six low cycles for a write, nine for a read
  sequence s_load_low;
    !load_pulse_n [*6] ##1 load_pulse_n;
  endsequence
  sequence s_unload_low;
    !unload_pulse_n [*8] ##1 !unload_pulse_n ##1 unload_pulse_n;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_load_width: assert property ($fell(load_pulse_n) |-> s_load_low)
    else $error("write strobe width wrong");
  a_unload_width: assert property ($fell(unload_pulse_n) |-> s_unload_low)
    else $error("read strobe width wrong");
  a_load_cause: assert property ($fell(load_pulse_n) |-> $past(wr_data))
    else $error("write strobe without command");
  a_unload_cause: assert property ($fell(unload_pulse_n) |-> $past(wr_rcmd))
    else $error("read strobe without command");
  a_din_hold: assert property (!load_pulse_n && $past(!load_pulse_n) |-> $stable(fifo_din))
    else $error("data moved under write strobe");
  a_strobe_excl: assert property (load_pulse_n || unload_pulse_n)
    else $error("both strobes low");
  a_clear_quiet: assert property (!clear_input |-> load_pulse_n && unload_pulse_n)
    else $error("strobe during clear");
  a_replay_quiet: assert property (!replay_strobe |-> load_pulse_n && unload_pulse_n)
    else $error("strobe during replay");
endmodule // afc_ctrl_monitor

bind afc_ctrl afc_ctrl_monitor #(.DW(DW)) u_mon (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .load_pulse_n, .unload_pulse_n,
  .clear_input, .replay_strobe, .fifo_din);

// ==== testbench/afc_fifo_model.sv ====
`timescale 1ns/100ps
// strobe-driven fifo device, depth shortened so the bench can fill it
module afc_fifo_model #(
  parameter int DEPTH = 8
) (
  // strobes and controls
  input wire logic load_pulse_n,
  input wire logic unload_pulse_n,
  input wire logic clear_input,
  input wire logic replay_strobe,
  input wire logic [8:0] fifo_din,
  // flags and data
  output logic full_flag_n,
  output logic empty_indicator_n,
  output logic half_level_indicator_n,
  output logic [8:0] fifo_dout
);
  logic [8:0] mem [DEPTH];
  int wp;
  int rp;
  int cnt;
  // pointers count modulo twice the depth so full and empty differ
  assign cnt = (wp - rp + 2 * DEPTH) % (2 * DEPTH);
  assign full_flag_n = (cnt != DEPTH);
  assign empty_indicator_n = (cnt != 0);
  assign half_level_indicator_n = (cnt <= DEPTH / 2);
  // released bus shows the inverse, so stale data never passes
  assign fifo_dout = unload_pulse_n ? ~mem[rp % DEPTH] : mem[rp % DEPTH];
  // store on the rising write edge, only while not full
  // an unknown clear at power-up must not let the first strobe edge store a word
  always @(negedge clear_input or posedge load_pulse_n) begin
    if (!clear_input) wp <= 0;
    else if (clear_input && full_flag_n) begin
      mem[wp % DEPTH] <= fifo_din;
      wp <= (wp + 1) % (2 * DEPTH);
    end
  end
  // read pointer: clear and replay jump to zero, a read edge advances
  always @(negedge clear_input or negedge replay_strobe or posedge unload_pulse_n) begin
    if (!clear_input || !replay_strobe) rp <= 0;
    else if (empty_indicator_n) rp <= (rp + 1) % (2 * DEPTH);
  end
endmodule // afc_fifo_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
// controller against the behavioural fifo device
module tb;
  localparam int DEPTH = 8;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} afc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o, load_pulse_n, unload_pulse_n, clear_input, replay_strobe, lead_unit_select;
  logic full_flag_n, empty_indicator_n, half_level_indicator_n;
  logic [8:0] fifo_din, fifo_dout;
  int n_fail = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  // ordinary cases: write rows wait for idle, read rows compare
  afc_row_t rows [13] = '{'{1'b0, 8'h10, 32'h0, 32'h05}, '{1'b1, 8'h04, 32'h1a5, 32'h0},
    '{1'b1, 8'h04, 32'h0c3, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h07},
    '{1'b1, 8'h08, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h1a5},
    '{1'b1, 8'h08, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h0c3},
    '{1'b0, 8'h10, 32'h0, 32'h05}, '{1'b1, 8'h08, 32'h0, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'h15}, '{1'b1, 8'h10, 32'h10, 32'h0},
    '{1'b0, 8'h14, 32'h0, 32'h0}};

  afc_ctrl #(.DW(9), .N_DEV(1)) uut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .load_pulse_n, .unload_pulse_n,
    .clear_input, .replay_strobe, .lead_unit_select, .fifo_din, .full_flag_n,
    .empty_indicator_n, .half_level_indicator_n, .fifo_dout);
  afc_fifo_model #(.DEPTH(DEPTH)) u_dev (.load_pulse_n, .unload_pulse_n, .clear_input,
    .replay_strobe, .fifo_din, .full_flag_n, .empty_indicator_n, .half_level_indicator_n,
    .fifo_dout);

  // free-running clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // hang guard, far above the several hundred cycles needed
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  // commands are refused while busy, so every write waits it out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    do bus(1'b0, afc_pkg::REG_STATUS, 32'h0); while (q[afc_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", q, e);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h14, 32'hff);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    end
    $display("table done");
    for (int i = 0; i <= DEPTH; i++) wr(afc_pkg::REG_WDATA, 32'(i));
    rd(afc_pkg::REG_STATUS, 32'h12);
    wr(afc_pkg::REG_STATUS, 32'h10);
    for (int i = 0; i < DEPTH; i++) begin
      wr(afc_pkg::REG_RCMD, 32'h0);
      rd(afc_pkg::REG_RDATA, 32'(i));
    end
    rd(afc_pkg::REG_STATUS, 32'h05);
    $display("fill and drain done");
    wr(afc_pkg::REG_CTRL, 32'h01);
    rd(afc_pkg::REG_STATUS, 32'h05);
    wr(afc_pkg::REG_WDATA, 32'h11);
    wr(afc_pkg::REG_WDATA, 32'h22);
    wr(afc_pkg::REG_RCMD, 32'h0);
    rd(afc_pkg::REG_RDATA, 32'h11);
    wr(afc_pkg::REG_CTRL, 32'h02);
    wr(afc_pkg::REG_RCMD, 32'h0);
    rd(afc_pkg::REG_STATUS, 32'h27);
    rd(afc_pkg::REG_RDATA, 32'h11);
    $display("replay done");
    wr(afc_pkg::REG_CTRL, 32'h0c);
    // past half full, so the device's half-level flag is low but must read released
    for (int i = 0; i < 4; i++) wr(afc_pkg::REG_WDATA, 32'h0);
    wr(afc_pkg::REG_CTRL, 32'h0e);
    rd(afc_pkg::REG_STATUS, 32'h17);
    chk("lead", 32'(lead_unit_select), 32'h1);
    $display("depth mode done");
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(8'h14, 32'hff);
    rd(afc_pkg::REG_STATUS, 32'h05);
    chk("lead", 32'(lead_unit_select), 32'h0);
    $display("second reset done");
    stop_test();
  end
endmodule // tb
